// [design/msu_core.sv]
// Miscellaneous system instruction execution unit with an AHB-Lite status and control slave.
`timescale 1ns/1ns
// What this block does
// [RULE1] mask clear variant clears, set variant sets
// [RULE2] flags pick base mask and/or fault block
// [RULE3] unprivileged mask change does nothing, no fault
// [RULE4] mask change ignores condition pass
// [RULE5] memory fence orders explicit memory accesses
// [RULE6] memory fence never stalls non-memory instructions
// [RULE7] drain fence stalls until accesses complete
// [RULE8] refetch fence flushes pipeline after completing
// [RULE9] special read copies register; no SP/PC destination
// [RULE10] unprivileged load reaches only application flags
// [RULE11] unprivileged status load drops unallocated/state bits
// [RULE12] raise-only alias writes only nonzero higher priority
// [RULE13] alias read returns plain masking level
// [RULE14] load source must not be SP/PC
// [RULE15] load into flags register updates flags
// [RULE16] no-operation may retire in zero cycles
// [RULE17] event broadcast signals all, sets event register
// [RULE18] supervisor call raises exception, ignores immediate
// [RULE19] event sleep waits for listed wake causes
// [RULE20] event sleep with event set clears, continues
// [RULE21] interrupt sleep wakes on exception or debug request
// [RULE22] listed operations leave condition flags unchanged
// [RULE23] debug halt enters debug, ignores condition
// [RULE24] sleep request high while suspended, drops on wake
module msu_core (
  input  wire logic        hclk,          // Core clock.
  input  wire logic        hresetn,       // Asynchronous reset, active low.
  input  wire logic        op_valid,      // Instruction presented this cycle.
  input  wire logic [3:0]  op_code,       // Operation code.
  input  wire logic        op_cond_pass,  // Condition check result.
  input  wire logic        op_priv,       // Privileged execution.
  input  wire logic [1:0]  op_effect,     // Bit0 set variant; bit1 unused.
  input  wire logic [1:0]  op_flags,      // Bit0 base mask, bit1 fault block.
  input  wire logic [3:0]  op_sreg,       // Special register selector.
  input  wire logic [3:0]  op_rnum,       // General register number.
  input  wire logic [31:0] op_src,        // Source value for loads.
  input  wire logic [31:0] ext_sp,        // Current stack pointer value.
  input  wire logic        mem_busy,      // Explicit accesses still outstanding.
  input  wire logic        exc_unmasked,  // Unmasked exception wants service.
  input  wire logic        exc_any,       // Any exception request.
  input  wire logic        exc_new_pend,  // Exception became pending.
  input  wire logic        dbg_req,       // Debug entry request.
  input  wire logic        dbg_en,        // Debug enabled.
  input  wire logic        ext_event,     // External event input.
  input  wire logic [31:0] haddr,         // Bus address.
  input  wire logic [1:0]  htrans,        // Bus transfer type.
  input  wire logic        hwrite,        // Bus write.
  input  wire logic [2:0]  hsize,         // Bus size.
  input  wire logic [31:0] hwdata,        // Bus write data.
  input  wire logic        hsel,          // Slave select.
  input  wire logic        hready,        // Bus ready in.
  output logic             op_ready_ff,   // Executor accepts an instruction.
  output logic             mem_hold_ff,   // Hold later memory accesses.
  output logic             flush_ff,      // Pipeline flush pulse.
  output logic             wb_en_ff,      // General register write pulse.
  output logic [3:0]       wb_num_ff,     // General register number.
  output logic [31:0]      wb_data_ff,    // General register data.
  output logic             event_out_ff,  // Event broadcast pulse.
  output logic             svc_req_ff,    // Supervisor call exception pulse.
  output logic             dbg_halt_ff,   // Debug state entry pulse.
  output logic             sleep_req_ff,  // Sleep request to power management.
  output logic             undef_ff,      // Illegal register operand pulse.
  output logic [31:0]      hrdata_ff,     // Bus read data.
  output logic             hreadyout_ff,  // Bus ready out.
  output logic             hresp_ff       // Bus response, always OKAY.
);
  // Architectural state.
  logic             bim_ff;
  logic             gfb_ff;
  logic [7:0]       lvl_ff;
  logic [31:0]      psr_ff;
  logic [1:0]       ctrl_ff;
  logic             evreg_ff;
  logic             pend_wake_ff;
  logic             sleep_ish_ff;
  msu_pkg::msu_state_t st_ff;
  msu_pkg::msu_state_t nxt_st;
  logic             bus_wr_ff;
  logic [7:0]       bus_off_ff;

  // Returns one when a register number names SP or PC.
  function automatic logic bad_reg(input logic [3:0] r);
    bad_reg = (r == msu_pkg::REG_SP) || (r == msu_pkg::REG_PC);
  endfunction

  // Decode of the presented instruction.
  wire        take     = op_valid && op_ready_ff;
  wire        op_eff   = take && (op_cond_pass || op_code == msu_pkg::OP_CPS || op_code == msu_pkg::OP_HALT);
  wire        is_cps   = op_eff && op_code == msu_pkg::OP_CPS && op_priv;           // see [RULE3] see [RULE4]
  wire        is_adf   = op_eff && op_code == msu_pkg::OP_ADF;
  wire        is_prf   = op_eff && op_code == msu_pkg::OP_PRF;
  wire        is_srr   = op_eff && op_code == msu_pkg::OP_SRR;
  wire        is_srl   = op_eff && op_code == msu_pkg::OP_SRL;
  wire        is_evb   = op_eff && op_code == msu_pkg::OP_EVB;
  wire        is_esh   = op_eff && op_code == msu_pkg::OP_ESH;
  wire        is_ish   = op_eff && op_code == msu_pkg::OP_ISH;
  wire        rd_bad   = is_srr && bad_reg(op_rnum);                                 // see [RULE9]
  wire        rn_bad   = is_srl && bad_reg(op_rnum);                                 // see [RULE14]
  wire        srl_ok   = is_srl && !rn_bad;
  wire        srl_app  = srl_ok && op_sreg == msu_pkg::SR_APP;
  wire        srl_psr  = srl_ok && op_sreg == msu_pkg::SR_PSR;
  wire        srl_priv = srl_ok && op_priv;                                          // see [RULE10]
  wire [31:0] psr_wm   = op_priv ? msu_pkg::PSR_ALL_WM : msu_pkg::PSR_USR_WM;       // see [RULE11]
  wire [31:0] psr_nxt  = (psr_ff & ~psr_wm) | (op_src & psr_wm);
  wire [7:0]  src_lvl  = op_src[msu_pkg::LVL_W-1:0];
  wire        lvl_raise = src_lvl != msu_pkg::LVL_ZERO &&
                          (lvl_ff == msu_pkg::LVL_ZERO || src_lvl < lvl_ff);        // see [RULE12]

  // Read value of a special register; the alias reads as the plain level.
  wire [31:0] srr_val =
    (op_sreg == msu_pkg::SR_APP)   ? (psr_ff & msu_pkg::PSR_USR_WM) :
    (op_sreg == msu_pkg::SR_PSR)   ? psr_ff :
    (op_sreg == msu_pkg::SR_BIM)   ? {31'h0, bim_ff} :
    (op_sreg == msu_pkg::SR_LVL ||
     op_sreg == msu_pkg::SR_LVLMX) ? {24'h0, lvl_ff} :                               // see [RULE13]
    (op_sreg == msu_pkg::SR_GFB)   ? {31'h0, gfb_ff} :
    (op_sreg == msu_pkg::SR_CTRL)  ? {30'h0, ctrl_ff} :
    (op_sreg == msu_pkg::SR_SP)    ? ext_sp : msu_pkg::ZERO32;                       // see [RULE9]

  // Wake conditions for both sleep hints.
  wire wake_esh = exc_unmasked || (exc_new_pend && pend_wake_ff) || (dbg_req && dbg_en) || ext_event;  // see [RULE19]
  wire wake_ish = exc_any || dbg_req;                                                // see [RULE21]
  wire wake     = sleep_ish_ff ? wake_ish : wake_esh;

  // Executor next state: drain fence stalls, sleep hints suspend.
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      msu_pkg::ST_RUN: begin
        if (is_adf && mem_busy) begin
          nxt_st = msu_pkg::ST_DRAIN;                                                // see [RULE7]
        end else if ((is_esh && !evreg_ff) || is_ish) begin
          nxt_st = msu_pkg::ST_SLEEP;                                                // see [RULE19] see [RULE21]
        end
      end
      msu_pkg::ST_DRAIN: if (!mem_busy) nxt_st = msu_pkg::ST_RUN;
      msu_pkg::ST_SLEEP: if (wake) nxt_st = msu_pkg::ST_RUN;                          // see [RULE24]
      default: nxt_st = msu_pkg::ST_RUN;
    endcase
  end

  // Executor state and handshake outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff        <= msu_pkg::ST_RUN;
      op_ready_ff  <= 1'b1;
      sleep_req_ff <= 1'b0;
      sleep_ish_ff <= 1'b0;
      mem_hold_ff  <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      op_ready_ff  <= nxt_st == msu_pkg::ST_RUN;                                     // see [RULE7] see [RULE16]
      sleep_req_ff <= nxt_st == msu_pkg::ST_SLEEP;                                   // see [RULE24]
      sleep_ish_ff <= (st_ff == msu_pkg::ST_RUN) ? is_ish : sleep_ish_ff;
      // The memory fence only holds later memory accesses, never the pipeline.
      mem_hold_ff  <= ((op_eff && op_code == msu_pkg::OP_MOF) || mem_hold_ff) && mem_busy;  // see [RULE5] see [RULE6]
    end
  end

  // Pulses to the pipeline, exception and debug logic.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flush_ff     <= 1'b0;
      wb_en_ff     <= 1'b0;
      wb_num_ff    <= 4'h0;
      wb_data_ff   <= msu_pkg::ZERO32;
      event_out_ff <= 1'b0;
      svc_req_ff   <= 1'b0;
      dbg_halt_ff  <= 1'b0;
      undef_ff     <= 1'b0;
    end else begin
      flush_ff     <= is_prf;                                                        // see [RULE8]
      wb_en_ff     <= is_srr && !rd_bad;                                             // see [RULE9]
      wb_num_ff    <= op_rnum;
      wb_data_ff   <= srr_val;
      event_out_ff <= is_evb;                                                        // see [RULE17]
      svc_req_ff   <= op_eff && op_code == msu_pkg::OP_SVC;                          // see [RULE18]
      dbg_halt_ff  <= op_eff && op_code == msu_pkg::OP_HALT;                         // see [RULE23]
      undef_ff     <= rd_bad || rn_bad;
    end
  end

  // Mask registers, masking level and control.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bim_ff  <= 1'b0;
      gfb_ff  <= 1'b0;
      lvl_ff  <= msu_pkg::LVL_ZERO;
      ctrl_ff <= 2'b00;
    end else begin
      if (is_cps && op_flags[0]) bim_ff <= op_effect[0];                             // see [RULE1] see [RULE2]
      else if (srl_priv && op_sreg == msu_pkg::SR_BIM) bim_ff <= op_src[0];
      if (is_cps && op_flags[1]) gfb_ff <= op_effect[0];                             // see [RULE1] see [RULE2]
      else if (srl_priv && op_sreg == msu_pkg::SR_GFB) gfb_ff <= op_src[0];
      if (srl_priv && op_sreg == msu_pkg::SR_LVL) lvl_ff <= src_lvl;
      else if (srl_priv && op_sreg == msu_pkg::SR_LVLMX && lvl_raise) lvl_ff <= src_lvl;  // see [RULE12]
      if (srl_priv && op_sreg == msu_pkg::SR_CTRL) ctrl_ff <= op_src[msu_pkg::CTRL_W-1:0];
    end
  end

  // Status register: only a load into a flags-holding register changes it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psr_ff <= msu_pkg::ZERO32;
    end else if (srl_app) begin
      psr_ff <= (psr_ff & ~msu_pkg::PSR_USR_WM) | (op_src & msu_pkg::PSR_USR_WM);   // see [RULE10] see [RULE15]
    end else if (srl_psr) begin
      psr_ff <= psr_nxt;                                                             // see [RULE11] see [RULE15] see [RULE22]
    end
  end

  // Local event register; a set wins over the clear by an event sleep.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evreg_ff <= 1'b0;
    end else if (is_evb || ext_event) begin
      evreg_ff <= 1'b1;                                                              // see [RULE17]
    end else if (is_esh && evreg_ff) begin
      evreg_ff <= 1'b0;                                                              // see [RULE20]
    end
  end

  // Bus slave: one wait-free data phase per transfer.
  wire bus_go = hsel && hready && htrans == msu_pkg::HTRANS_NSQ;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_ff    <= 1'b0;
      bus_off_ff   <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      pend_wake_ff <= 1'b0;
    end else begin
      bus_wr_ff    <= bus_go && hwrite;
      bus_off_ff   <= haddr[7:0];
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      if (bus_wr_ff && bus_off_ff == msu_pkg::OFF_CTRL) pend_wake_ff <= hwdata[0];
    end
  end

  // Read data is registered in the address phase so it stands in the data phase.
  wire [31:0] rd_mux =
    (haddr[7:0] == msu_pkg::OFF_CTRL)   ? {31'h0, pend_wake_ff} :
    (haddr[7:0] == msu_pkg::OFF_STATUS) ? {27'h0, evreg_ff, sleep_req_ff, st_ff, op_ready_ff} :
    (haddr[7:0] == msu_pkg::OFF_MASKS)  ? {22'h0, lvl_ff, gfb_ff, bim_ff} :
    (haddr[7:0] == msu_pkg::OFF_PSR)    ? psr_ff : msu_pkg::ZERO32;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_ff <= msu_pkg::ZERO32;
    else if (bus_go && !hwrite) hrdata_ff <= rd_mux;
  end

  // Checks.
  chk_mask_unpriv: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE3]
    (take && op_code == msu_pkg::OP_CPS && !op_priv) |=> $stable(bim_ff) && $stable(gfb_ff))
    else $error("mask changed by unprivileged op");
  chk_mask_set: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE1]
    (take && op_code == msu_pkg::OP_CPS && op_priv && op_flags[0]) |=> bim_ff == $past(op_effect[0]))
    else $error("base mask not updated");
  chk_fault_set: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE2]
    (take && op_code == msu_pkg::OP_CPS && op_priv && op_flags[1]) |=> gfb_ff == $past(op_effect[0]))
    else $error("fault block not updated");
  chk_drain_stall: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE7]
    (st_ff == msu_pkg::ST_DRAIN && mem_busy) |=> !op_ready_ff)
    else $error("drain fence let work through");
  chk_mof_nostall: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE6]
    (take && op_code == msu_pkg::OP_MOF) |=> op_ready_ff)
    else $error("memory fence stalled the pipeline");
  chk_prf_flush: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE8]
    is_prf |=> flush_ff)
    else $error("refetch fence did not flush");
  chk_srr_dest: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE9]
    rd_bad |=> undef_ff && !wb_en_ff)
    else $error("illegal read destination written");
  chk_flags_kept: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE22]
    (take && op_code != msu_pkg::OP_SRL) |=> $stable(psr_ff))
    else $error("flags changed by non-load op");
  chk_evb_sets: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE17]
    is_evb |=> evreg_ff && event_out_ff)
    else $error("event broadcast missing");
  chk_esh_skip: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE20]
    (is_esh && evreg_ff && !ext_event) |=> !evreg_ff && !sleep_req_ff)
    else $error("event sleep did not skip");
  chk_esh_sleep: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE19]
    (is_esh && !evreg_ff) |=> sleep_req_ff && !op_ready_ff)
    else $error("event sleep did not suspend");
  sequence s_sleeping;
    st_ff == msu_pkg::ST_SLEEP && !wake;
  endsequence
  chk_sleep_req: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE24]
    s_sleeping |=> sleep_req_ff)
    else $error("sleep request dropped");
  chk_ish_wake: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE21]
    (st_ff == msu_pkg::ST_SLEEP && sleep_ish_ff && dbg_req) |=> !sleep_req_ff && op_ready_ff)
    else $error("debug request failed to wake");
  chk_lvl_raise: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE12]
    (srl_priv && op_sreg == msu_pkg::SR_LVLMX && !lvl_raise) |=> $stable(lvl_ff))
    else $error("alias lowered the level");
  chk_halt_uncond: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE23]
    (take && op_code == msu_pkg::OP_HALT) |=> dbg_halt_ff)
    else $error("debug halt not raised");
  chk_svc_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE18]
    (op_eff && op_code == msu_pkg::OP_SVC) |=> svc_req_ff ##1 (!svc_req_ff || $past(is_srl || take)))
    else $error("supervisor call not raised");
endmodule

// [include/msu_pkg.sv]
// Package with opcodes, special-register selectors, bus offsets and field positions of the system instruction unit.
package msu_pkg;
  // Operation codes presented by the pipeline.
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_CPS   = 4'h1,
    OP_MOF   = 4'h2,
    OP_ADF   = 4'h3,
    OP_PRF   = 4'h4,
    OP_SRR   = 4'h5,
    OP_SRL   = 4'h6,
    OP_NOOP  = 4'h7,
    OP_EVB   = 4'h8,
    OP_SVC   = 4'h9,
    OP_ESH   = 4'ha,
    OP_ISH   = 4'hb,
    OP_HALT  = 4'hc
  } msu_op_t;

  // Special register selectors.
  localparam logic [3:0] SR_APP   = 4'h0;
  localparam logic [3:0] SR_PSR   = 4'h1;
  localparam logic [3:0] SR_BIM   = 4'h2;
  localparam logic [3:0] SR_LVL   = 4'h3;
  localparam logic [3:0] SR_LVLMX = 4'h4;
  localparam logic [3:0] SR_GFB   = 4'h5;
  localparam logic [3:0] SR_CTRL  = 4'h6;
  localparam logic [3:0] SR_SP    = 4'h7;

  // Executor states; RUN to DRAIN flips one bit, RUN to SLEEP flips two.
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DRAIN = 2'b01,
    ST_SLEEP = 2'b11
  } msu_state_t;

  // Register bus byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASKS  = 8'h08;
  localparam logic [7:0] OFF_PSR    = 8'h0c;

  // Field positions and widths.
  localparam int          FLAG_LO    = 27;
  localparam int          FLAG_W     = 5;
  localparam logic [31:0] PSR_USR_WM = 32'hf800_0000;
  localparam logic [31:0] PSR_ALL_WM = 32'hf800_01ff;
  localparam int          LVL_W      = 8;
  localparam logic [7:0]  LVL_ZERO   = 8'h00;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NSQ = 2'b10;
  localparam logic [3:0]  REG_SP     = 4'hd;
  localparam logic [3:0]  REG_PC     = 4'hf;
  localparam int          CTRL_W     = 2;
endpackage

// [bench/test_misc_system_instruction_unit.sv]
// Self-checking testbench of the system instruction unit, driving its pipeline and bus ports.
`timescale 1ns/1ns
module test_misc_system_instruction_unit;
  logic        hclk, hresetn, op_valid, op_cond_pass, op_priv, mem_busy, exc_unmasked, exc_any;
  logic        exc_new_pend, dbg_req, dbg_en, ext_event, hwrite, hsel, op_ready_ff, mem_hold_ff;
  logic        flush_ff, wb_en_ff, event_out_ff, svc_req_ff, dbg_halt_ff, sleep_req_ff, undef_ff;
  logic        hreadyout_ff, hresp_ff;
  logic [1:0]  op_effect, op_flags, htrans;
  logic [2:0]  hsize;
  logic [3:0]  op_code, op_sreg, op_rnum, wb_num_ff;
  logic [5:0]  pl;
  logic [31:0] op_src, ext_sp, haddr, hwdata, wb_data_ff, hrdata_ff, rd;
  int          errors, checks_done, cycles;

  // The single slave's ready output is the bus ready; every other port matches by name.
  msu_core u_dut (.hready(hreadyout_ff), .*);

  // Free-running core clock of 100 ns.
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Cuts a hang short and reports it as a mismatch.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH timeout expected finish seen hang");
      stop_test();
    end
  end

  task automatic stop_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Presents one instruction, holds it until taken, then snapshots the one-cycle pulses.
  task automatic op(input logic [3:0] code, input logic priv, cond, input logic [1:0] eff, flg,
                    input logic [3:0] sreg, rnum, input logic [31:0] src);
    @(posedge hclk);
    op_valid <= 1'b1;
    op_code <= code;
    op_priv <= priv;
    op_cond_pass <= cond;
    op_effect <= eff;
    op_flags <= flg;
    op_sreg <= sreg;
    op_rnum <= rnum;
    op_src <= src;
    @(negedge hclk);
    while (op_ready_ff !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    op_valid <= 1'b0;
    @(negedge hclk);
    pl = {flush_ff, wb_en_ff, event_out_ff, svc_req_ff, dbg_halt_ff, undef_ff};
  endtask

  // One single word transfer: address phase, then data phase, each held until ready.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= msu_pkg::HTRANS_NSQ;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    hsize <= 3'h2;
    @(negedge hclk);
    while (hreadyout_ff !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(negedge hclk);
    while (hreadyout_ff !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    rd = hrdata_ff;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, msu_pkg::ZERO32);
    chk(what, exp, rd);
  endtask

  // Mask change: both variants, both targets, failed condition and unprivileged use.
  task automatic t_masks;
    op(msu_pkg::OP_CPS, 1'b1, 1'b1, 2'h1, 2'h1, 4'h0, 4'h0, 32'h0);
    rd_chk("masks base set", msu_pkg::OFF_MASKS, 32'h1);
    op(msu_pkg::OP_CPS, 1'b1, 1'b0, 2'h1, 2'h2, 4'h0, 4'h0, 32'h0);
    rd_chk("masks fault set", msu_pkg::OFF_MASKS, 32'h3);
    op(msu_pkg::OP_CPS, 1'b0, 1'b1, 2'h0, 2'h3, 4'h0, 4'h0, 32'h0);
    chk("unpriv pulses", 32'h0, pl);
    rd_chk("masks unpriv", msu_pkg::OFF_MASKS, 32'h3);
    op(msu_pkg::OP_CPS, 1'b1, 1'b1, 2'h0, 2'h3, 4'h0, 4'h0, 32'h0);
    rd_chk("masks cleared", msu_pkg::OFF_MASKS, 32'h0);
  endtask

  // Masking level through the raise-only alias, and special reads.
  task automatic t_levels;
    op(msu_pkg::OP_SRL, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_LVLMX, 4'h1, 32'h30);
    rd_chk("alias from zero", msu_pkg::OFF_MASKS, 32'hc0);
    op(msu_pkg::OP_SRL, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_LVLMX, 4'h1, 32'h0);
    op(msu_pkg::OP_SRL, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_LVLMX, 4'h1, 32'h40);
    op(msu_pkg::OP_SRL, 1'b0, 1'b1, 2'h0, 2'h0, msu_pkg::SR_LVL, 4'h1, 32'h05);
    rd_chk("alias zero higher unpriv", msu_pkg::OFF_MASKS, 32'hc0);
    op(msu_pkg::OP_SRL, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_LVLMX, 4'h1, 32'h10);
    rd_chk("alias lower", msu_pkg::OFF_MASKS, 32'h40);
    op(msu_pkg::OP_SRR, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_LVLMX, 4'h3, 32'h0);
    chk("alias read", 32'h10, wb_data_ff);
    chk("alias read dest", 32'h13, {wb_en_ff, wb_num_ff});
    op(msu_pkg::OP_SRR, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_SP, 4'h2, 32'h0);
    chk("sp read", ext_sp, wb_data_ff);
    op(msu_pkg::OP_SRR, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_BIM, 4'hd, 32'h0);
    chk("read to sp", 32'h1, pl);
  endtask

  // Status loads by privilege, illegal source, then flags kept by the other operations.
  task automatic t_psr;
    logic [3:0] cl[7] = '{4'h7, 4'h2, 4'h4, 4'h8, 4'h9, 4'hc, 4'h1};
    logic [5:0] pe[7] = '{6'h00, 6'h00, 6'h20, 6'h08, 6'h04, 6'h02, 6'h00};
    op(msu_pkg::OP_SRL, 1'b0, 1'b1, 2'h0, 2'h0, msu_pkg::SR_APP, 4'h1, 32'hffff_ffff);
    rd_chk("unpriv flags", msu_pkg::OFF_PSR, 32'hf800_0000);
    op(msu_pkg::OP_SRL, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_PSR, 4'h1, 32'hffff_ffff);
    op(msu_pkg::OP_SRL, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_APP, 4'h1, 32'h0);
    rd_chk("flags cleared", msu_pkg::OFF_PSR, 32'h0000_01ff);
    op(msu_pkg::OP_SRL, 1'b1, 1'b1, 2'h0, 2'h0, msu_pkg::SR_PSR, 4'hf, 32'hffff_ffff);
    chk("load from pc", 32'h1, pl);
    op(msu_pkg::OP_HALT, 1'b1, 1'b0, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    chk("halt cond fail", 32'h2, pl);
    for (int i = 0; i < 7; i++) begin
      op(cl[i], 1'b1, 1'b1, 2'h1, 2'h0, 4'h0, 4'h0, 32'h0000_00ff);
      chk("op pulses", pe[i], pl);
      chk("no stall", 32'h1, op_ready_ff);
    end
    rd_chk("flags kept", msu_pkg::OFF_PSR, 32'h0000_01ff);
  endtask

  // Fences against outstanding memory accesses.
  task automatic t_fence;
    @(posedge hclk);
    mem_busy <= 1'b1;
    op(msu_pkg::OP_MOF, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    chk("fence hold", 32'h3, {mem_hold_ff, op_ready_ff});
    op(msu_pkg::OP_NOOP, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    chk("hold after nop", 32'h1, mem_hold_ff);
    @(posedge hclk);
    mem_busy <= 1'b0;
    repeat (3) @(negedge hclk);
    chk("hold released", 32'h0, mem_hold_ff);
    @(posedge hclk);
    mem_busy <= 1'b1;
    op(msu_pkg::OP_ADF, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    repeat (4) @(negedge hclk);
    chk("drain stall", 32'h0, op_ready_ff);
    @(posedge hclk);
    mem_busy <= 1'b0;
    repeat (3) @(negedge hclk);
    chk("drain done", 32'h1, op_ready_ff);
  endtask

  // Sleep hints with the event register set and clear, and their wake causes.
  task automatic t_sleep;
    rd_chk("event set", msu_pkg::OFF_STATUS, 32'h11);
    op(msu_pkg::OP_ESH, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    chk("no sleep", 32'h1, {sleep_req_ff, op_ready_ff});
    op(msu_pkg::OP_ESH, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    chk("event sleep", 32'h1, sleep_req_ff);
    @(posedge hclk);
    dbg_req <= 1'b1;
    exc_new_pend <= 1'b1;
    repeat (4) @(negedge hclk);
    chk("still asleep", 32'h1, sleep_req_ff);
    ahb(1'b1, msu_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(negedge hclk);
    chk("pend wake", 32'h1, {sleep_req_ff, op_ready_ff});
    @(posedge hclk);
    exc_new_pend <= 1'b0;
    rd_chk("control", msu_pkg::OFF_CTRL, 32'h1);
    rd_chk("unmapped", 8'h10, 32'h0);
    op(msu_pkg::OP_ISH, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    repeat (3) @(negedge hclk);
    chk("debug wake", 32'h1, {sleep_req_ff, op_ready_ff});
    @(posedge hclk);
    dbg_req <= 1'b0;
    op(msu_pkg::OP_ESH, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    @(posedge hclk);
    ext_event <= 1'b1;
    repeat (3) @(negedge hclk);
    chk("event wake", 32'h1, {sleep_req_ff, op_ready_ff});
    @(posedge hclk);
    ext_event <= 1'b0;
    op(msu_pkg::OP_ISH, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, 4'h0, 32'h0);
    @(posedge hclk);
    exc_any <= 1'b1;
    repeat (3) @(negedge hclk);
    chk("exception wake", 32'h1, {sleep_req_ff, op_ready_ff});
    @(posedge hclk);
    exc_any <= 1'b0;
  endtask

  // Main sequence: reset, register reset values, then each scenario.
  initial begin
    {hresetn, op_valid, op_cond_pass, op_priv, mem_busy, exc_unmasked, exc_any} = 7'h0;
    {exc_new_pend, dbg_req, dbg_en, ext_event, hwrite, hsel} = 6'h0;
    {op_effect, op_flags, htrans, hsize, op_code, op_sreg, op_rnum} = 21'h0;
    {op_src, haddr, hwdata} = 96'h0;
    ext_sp = 32'h2000_0ff0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("status reset", msu_pkg::OFF_STATUS, 32'h1);
    rd_chk("masks reset", msu_pkg::OFF_MASKS, 32'h0);
    t_masks();
    t_levels();
    t_psr();
    t_fence();
    t_sleep();
    stop_test();
  end
endmodule
